// file: rtl/elm_monitor.sv
// per-channel loss, zero-run and ais alarm monitor for an e1 interface
`timescale 1ns/1ps
module elm_monitor #(
  parameter int unsigned NCH = elm_pkg::N_CHAN,
  parameter int unsigned LONG_N = elm_pkg::DECLARE_LONG
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] loss_config,
  input wire logic [1:0] rx_format,
  input wire logic [1:0] tx_format,
  input wire logic rx_hdb3,
  input wire logic tx_hdb3,
  input wire logic rx_tick,
  input wire logic rx_mark,
  input wire logic [2:0] rx_amplitude,
  input wire logic rx_data_in,
  input wire logic rx_pos_in,
  input wire logic rx_neg_in,
  input wire logic rx_clock_in,
  input wire logic rx_sliced_pos,
  input wire logic rx_sliced_neg,
  input wire logic tx_tick,
  input wire logic tx_mark,
  input wire logic tx_out_tick,
  input wire logic [1:0] tx_out_amplitude,
  input wire logic ref_2m_clock,
  input wire logic loss_clock_select,
  input wire logic override_active,
  input wire logic override_data,
  input wire logic override_pos,
  input wire logic override_neg,
  input wire logic override_clock,
  input wire logic loss_edge_select,
  input wire logic tx_loss_edge_select,
  input wire logic ais_edge_select,
  input wire logic [7:0] flag_clear,
  input wire logic [7:0] flag_mask,
  input wire logic indication_clock_enable,
  input wire logic indication_clock_ctl,
  input wire logic [NCH-1:0] other_line_loss,
  output logic [7:0] loss_status,
  output logic [7:0] irq_flags,
  output logic irq_n,
  output logic rx_data_out,
  output logic rx_data_pos,
  output logic rx_data_neg,
  output logic rx_clock_out,
  output logic rx_multiplex_pin,
  output logic tx_multiplex_pin,
  output logic [4:0] error_events,
  output logic indication_clock,
  output logic line_signal_loss_o,
  output logic line_signal_loss_oe,
  output logic loss_serial_frame_o,
  output logic loss_serial_frame_oe
);
  localparam int unsigned DW = $clog2(LONG_N + 1);
  // channel field decode
  wire logic criteria_select = loss_config[7];
  wire logic [2:0] line_amplitude_threshold = loss_config[6:4];
  wire logic [1:0] tx_amplitude_threshold = loss_config[3:2];
  wire logic [1:0] tx_loss_period = loss_config[1:0];
  wire logic [DW-1:0] decl_len = criteria_select ? DW'(LONG_N) :
    DW'(elm_pkg::DECLARE_SHORT);
  // line side: low below q, high on a mark at q plus one 250 mv step or more
  wire logic line_low = rx_amplitude < line_amplitude_threshold;
  wire logic line_high = rx_mark &&
    ({1'b0, rx_amplitude} > {1'b0, line_amplitude_threshold});
  logic line_loss;
  elm_loss_counter #(.DECL_W(DW)) u_line (
    .clk(clk),
    .sys_rst(sys_rst),
    .bit_tick(rx_tick),
    .bit_low(line_low),
    .bit_high(line_high),
    .declare_len(decl_len),
    .loss(line_loss)
  );
  // system side only counted in dual-rail formats
  wire logic sys_dual = (tx_format == elm_pkg::ELM_TX_NRZ2) ||
    (tx_format == elm_pkg::ELM_TX_RZ2);
  logic sys_loss_raw;
  elm_loss_counter #(.DECL_W(DW)) u_sys (
    .clk(clk),
    .sys_rst(sys_rst),
    .bit_tick(tx_tick && sys_dual),
    .bit_low(!tx_mark),
    .bit_high(tx_mark),
    .declare_len(decl_len),
    .loss(sys_loss_raw)
  );
  wire logic sys_loss = sys_loss_raw && sys_dual;
  // transmit output: no valid pulse for the selected period
  function automatic logic [7:0] tx_period(input logic [1:0] sel);
    case (sel)
      2'b00: tx_period = 8'(elm_pkg::TX_PERIOD_0);
      2'b01: tx_period = 8'(elm_pkg::TX_PERIOD_1);
      2'b10: tx_period = 8'(elm_pkg::TX_PERIOD_2);
      default: tx_period = 8'(elm_pkg::TX_PERIOD_3);
    endcase
  endfunction
  logic [7:0] txl_cnt_r;
  logic tx_loss_r;
  // a floating shared line shows no pulse, so it counts as loss too
  wire logic tx_valid = tx_out_amplitude >= tx_amplitude_threshold &&
    tx_out_amplitude != 2'b00;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txl_cnt_r <= '0;
      tx_loss_r <= 1'b0;
    end else if (tx_out_tick) begin
      if (tx_valid) begin
        txl_cnt_r <= '0;
        tx_loss_r <= 1'b0;
      end else if (txl_cnt_r + 1'b1 >= tx_period(tx_loss_period)) begin
        tx_loss_r <= 1'b1;
      end else begin
        txl_cnt_r <= txl_cnt_r + 1'b1;
      end
    end
  end
  // excessive zero runs; ami limit when transmit is single rail
  function automatic logic [4:0] exz_limit(input logic hdb3);
    exz_limit = hdb3 ? 5'(elm_pkg::HDB3_EXZ) : 5'(elm_pkg::AMI_EXZ);
  endfunction
  wire logic tx_rule_hdb3 = tx_hdb3 &&
    (tx_format != elm_pkg::ELM_TX_NRZ1);
  logic [4:0] rz_r;
  logic [4:0] tz_r;
  logic rx_exz_r;
  logic tx_exz_r;
  wire logic rx_exz = rx_tick && !rx_mark && rz_r >= exz_limit(rx_hdb3);
  wire logic tx_exz = tx_tick && !tx_mark && tz_r >= exz_limit(tx_rule_hdb3);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rz_r <= '0;
      tz_r <= '0;
    end else begin
      if (rx_tick) begin
        rz_r <= rx_mark ? 5'h00 : (rx_exz ? rz_r : rz_r + 1'b1);
      end
      if (tx_tick) begin
        tz_r <= tx_mark ? 5'h00 : (tx_exz ? tz_r : tz_r + 1'b1);
      end
    end
  end
  // one pulse per zero run that crosses the limit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_exz_r <= 1'b0;
      tx_exz_r <= 1'b0;
    end else begin
      if (rx_tick) begin
        rx_exz_r <= rx_exz;
      end
      if (tx_tick) begin
        tx_exz_r <= tx_exz;
      end
    end
  end
  wire logic rx_exz_ev = rx_exz && !rx_exz_r;
  wire logic tx_exz_ev = tx_exz && !tx_exz_r;
  // ais: sparse zeros in 512-bit blocks, two blocks under g.775
  logic [9:0] ra_bits_r;
  logic [9:0] ta_bits_r;
  logic [1:0] ra_zero_r;
  logic [1:0] ta_zero_r;
  logic [1:0] ra_hist_r;
  logic [1:0] ta_hist_r;
  logic rx_ais_r;
  logic tx_ais_r;
  wire logic ra_end = rx_tick && ra_bits_r == 10'(elm_pkg::AIS_BLOCK - 1);
  wire logic ta_end = tx_tick && ta_bits_r == 10'(elm_pkg::AIS_BLOCK - 1);
  function automatic logic [1:0] zsat(input logic [1:0] z, input logic m);
    zsat = (m || z == 2'(elm_pkg::AIS_ZEROS)) ? z : z + 1'b1;
  endfunction
  wire logic [1:0] ra_znxt = zsat(ra_zero_r, rx_mark);
  wire logic [1:0] ta_znxt = zsat(ta_zero_r, tx_mark);
  wire logic ra_few = ra_znxt < 2'(elm_pkg::AIS_ZEROS);
  wire logic ta_few = ta_znxt < 2'(elm_pkg::AIS_ZEROS);
  // histories shift at block end; ais state follows criteria
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ra_bits_r <= '0;
      ra_zero_r <= '0;
      ra_hist_r <= '0;
      rx_ais_r <= 1'b0;
    end else if (rx_tick) begin
      ra_bits_r <= ra_end ? 10'h000 : ra_bits_r + 1'b1;
      ra_zero_r <= ra_end ? 2'h0 : ra_znxt;
      if (ra_end) begin
        ra_hist_r <= {ra_hist_r[0], ra_few};
        if (criteria_select) begin
          rx_ais_r <= ra_few;
        end else if (ra_few && ra_hist_r[0]) begin
          rx_ais_r <= 1'b1;
        end else if (!ra_few && !ra_hist_r[0]) begin
          rx_ais_r <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ta_bits_r <= '0;
      ta_zero_r <= '0;
      ta_hist_r <= '0;
      tx_ais_r <= 1'b0;
    end else if (tx_tick) begin
      ta_bits_r <= ta_end ? 10'h000 : ta_bits_r + 1'b1;
      ta_zero_r <= ta_end ? 2'h0 : ta_znxt;
      if (ta_end) begin
        ta_hist_r <= {ta_hist_r[0], ta_few};
        if (criteria_select) begin
          tx_ais_r <= ta_few;
        end else if (ta_few && ta_hist_r[0]) begin
          tx_ais_r <= 1'b1;
        end else if (!ta_few && !ta_hist_r[0]) begin
          tx_ais_r <= 1'b0;
        end
      end
    end
  end
  // status and edge-selected sticky flags; set beats clear
  logic [7:0] status_r;
  logic [7:0] flag_r;
  wire logic [7:0] status_nxt = {tx_ais_r, rx_ais_r, 3'b000, tx_loss_r,
    sys_loss, line_loss};
  wire logic [7:0] edge_sel = {ais_edge_select, ais_edge_select, 3'b000,
    tx_loss_edge_select, loss_edge_select, loss_edge_select};
  wire logic [7:0] status_ev = (status_nxt & ~status_r) |
    (edge_sel & (status_nxt ^ status_r));
  // loss and ais flags follow their status events;
  // exz flags sit in a register of their own
  wire logic [7:0] flag_set = status_ev;
  logic [7:0] exz_flag_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_r <= '0;
      flag_r <= '0;
      exz_flag_r <= '0;
    end else begin
      status_r <= status_nxt;
      flag_r <= (flag_r & ~flag_clear) | flag_set;
      exz_flag_r <= (exz_flag_r & ~flag_clear) |
        ({4'h0, tx_exz_ev, rx_exz_ev, 2'b00});
    end
  end
  assign loss_status = status_r;
  assign irq_flags = flag_r;
  // shared interrupt across both flag groups
  assign irq_n = !(|((flag_r | exz_flag_r) & ~flag_mask));
  // receive output forcing during line loss
  wire logic sliced = rx_format == elm_pkg::ELM_RX_SLICED;
  wire logic force_rx = line_loss && !override_active;
  wire logic loss_clk = loss_clock_select ? 1'b1 : ref_2m_clock;
  logic [3:0] rxo_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxo_r <= '0;
    end else if (override_active) begin
      rxo_r <= {override_data, override_pos, override_neg,
        override_clock};
    end else if (force_rx) begin
      rxo_r <= {1'b0, sliced & rx_sliced_pos, sliced & rx_sliced_neg,
        loss_clk};
    end else begin
      rxo_r <= {rx_data_in, rx_pos_in, rx_neg_in, rx_clock_in};
    end
  end
  assign rx_data_out = rxo_r[3];
  assign rx_data_pos = rxo_r[2];
  assign rx_data_neg = rxo_r[1];
  assign rx_clock_out = rxo_r[0];
  // events to counter and multiplex indication
  assign error_events = {tx_loss_r, sys_loss, line_loss, tx_exz_ev,
    rx_exz_ev};
  assign rx_multiplex_pin = line_loss || rx_exz_ev;
  assign tx_multiplex_pin = sys_loss || tx_loss_r || tx_exz_ev;
  // serial indication: this channel in slot 0, others from peers
  wire logic [NCH-1:0] all_loss = {other_line_loss[NCH-1:1], line_loss};
  elm_ind_serial #(.NCH(NCH), .DIV(elm_pkg::IND_DIV)) u_ind (
    .clk(clk),
    .sys_rst(sys_rst),
    .indication_clock_enable(indication_clock_enable),
    .indication_clock_ctl(indication_clock_ctl),
    .line_loss_all(all_loss),
    .indication_clock(indication_clock),
    .line_signal_loss_o(line_signal_loss_o),
    .line_signal_loss_oe(line_signal_loss_oe),
    .loss_serial_frame_o(loss_serial_frame_o),
    .loss_serial_frame_oe(loss_serial_frame_oe)
  );
endmodule

// file: rtl/elm_pkg.sv
// constants and types for the e1 loss-of-signal alarm monitor
package elm_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned N_CHAN = 22;
  localparam int unsigned DECLARE_SHORT = 32;
  localparam int unsigned DECLARE_LONG = 2048;
  localparam int unsigned CLEAR_LEN = 32;
  localparam int unsigned CLEAR_MARKS = 4;
  localparam int unsigned ZERO_RUN_MAX = 16;
  localparam int unsigned AMI_EXZ = 15;
  localparam int unsigned HDB3_EXZ = 3;
  localparam int unsigned AIS_BLOCK = 512;
  localparam int unsigned AIS_ZEROS = 3;
  localparam int unsigned TX_PERIOD_0 = 16;
  localparam int unsigned TX_PERIOD_1 = 32;
  localparam int unsigned TX_PERIOD_2 = 64;
  localparam int unsigned TX_PERIOD_3 = 128;
  localparam int unsigned IND_DIV = 4;
  localparam int unsigned FLAG_LINE_LOSS = 0;
  localparam int unsigned FLAG_SYS_LOSS = 1;
  localparam int unsigned FLAG_TX_LOSS = 2;
  localparam int unsigned FLAG_LINE_EXZ = 2;
  localparam int unsigned FLAG_SYS_EXZ = 3;
  localparam int unsigned FLAG_RX_AIS = 6;
  localparam int unsigned FLAG_TX_AIS = 7;
  typedef enum logic [1:0] {
    ELM_RX_NRZ1 = 2'b00,
    ELM_RX_NRZ2 = 2'b01,
    ELM_RX_RZ2 = 2'b10,
    ELM_RX_SLICED = 2'b11
  } elm_rx_fmt_t;
  typedef enum logic [1:0] {
    ELM_TX_NRZ1 = 2'b00,
    ELM_TX_NRZ2 = 2'b01,
    ELM_TX_RZ2 = 2'b10
  } elm_tx_fmt_t;
endpackage

// file: rtl/elm_loss_counter.sv
// declare/clear interval counter for one loss detector
`timescale 1ns/1ps
module elm_loss_counter #(
  parameter int unsigned DECL_W = 12
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bit_tick,
  input wire logic bit_low,
  input wire logic bit_high,
  input wire logic [DECL_W-1:0] declare_len,
  output logic loss
);
  logic loss_r;
  logic [DECL_W-1:0] low_r;
  logic [5:0] clr_r;
  logic [5:0] marks_r;
  logic [4:0] zrun_r;
  wire logic decl_hit = bit_low && (low_r + 1'b1 >= declare_len);
  wire logic clr_go = (clr_r != 6'h00) || bit_high;
  wire logic run_ok = bit_high || (zrun_r + 1'b1 < 5'(elm_pkg::ZERO_RUN_MAX));
  wire logic [5:0] marks_nxt = marks_r + 6'(bit_high);
  wire logic clr_end = clr_r + 1'b1 == 6'(elm_pkg::CLEAR_LEN);
  wire logic clr_done = clr_end && (marks_nxt >= 6'(elm_pkg::CLEAR_MARKS));
  assign loss = loss_r;
  // declare: run of low intervals; restart on break
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_r <= '0;
    end else if (bit_tick) begin
      low_r <= bit_low ? (decl_hit ? '0 : low_r + 1'b1) : '0;
    end
  end
  // window starts on a mark; a sparse one still closes at 32, no wrap
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clr_r <= '0;
      marks_r <= '0;
      zrun_r <= '0;
    end else if (bit_tick) begin
      if (!loss_r || !clr_go || !run_ok || clr_end) begin
        clr_r <= '0;
        marks_r <= '0;
        zrun_r <= '0;
      end else begin
        clr_r <= clr_r + 1'b1;
        marks_r <= marks_nxt;
        zrun_r <= bit_high ? 5'h00 : zrun_r + 1'b1;
      end
    end
  end
  // loss state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      loss_r <= 1'b0;
    end else if (bit_tick) begin
      if (!loss_r && decl_hit) begin
        loss_r <= 1'b1;
      end else if (loss_r && clr_go && run_ok && clr_done) begin
        loss_r <= 1'b0;
      end
    end
  end
endmodule

// file: rtl/elm_ind_serial.sv
// serial all-channel line-loss indication with frame pin
`timescale 1ns/1ps
module elm_ind_serial #(
  parameter int unsigned NCH = 22,
  parameter int unsigned DIV = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic indication_clock_enable,
  input wire logic indication_clock_ctl,
  input wire logic [NCH-1:0] line_loss_all,
  output logic indication_clock,
  output logic line_signal_loss_o,
  output logic line_signal_loss_oe,
  output logic loss_serial_frame_o,
  output logic loss_serial_frame_oe
);
  logic [7:0] div_r;
  logic clk_r;
  logic [4:0] slot_r;
  logic ser_r;
  logic frm_r;
  wire logic run = indication_clock_enable && indication_clock_ctl;
  wire logic rise = run && !clk_r && (div_r == 8'(DIV/2 - 1));
  wire logic fall = run && clk_r && (div_r == 8'(DIV/2 - 1));
  wire logic [4:0] slot_nxt = (slot_r == 5'(NCH-1)) ? 5'h00 : slot_r + 1'b1;
  assign indication_clock = clk_r;
  assign line_signal_loss_o = ser_r;
  assign loss_serial_frame_o = frm_r;
  assign line_signal_loss_oe = run;
  assign loss_serial_frame_oe = run;
  // clock divider; stops low when disabled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= '0;
      clk_r <= 1'b0;
    end else if (!run) begin
      div_r <= '0;
      clk_r <= 1'b0;
    end else if (rise || fall) begin
      div_r <= '0;
      clk_r <= !clk_r;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end
  // pins change with the rising edge of the output clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slot_r <= 5'(NCH-1);
      ser_r <= 1'b0;
      frm_r <= 1'b0;
    end else if (rise) begin
      slot_r <= slot_nxt;
      ser_r <= line_loss_all[slot_nxt];
      frm_r <= (slot_nxt == 5'h00);
    end
  end
endmodule

// file: verification/elm_monitor_assertions.sv
// port-level checks for the alarm monitor
`timescale 1ns/1ps
module elm_monitor_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] loss_status,
  input wire logic [7:0] irq_flags,
  input wire logic irq_n,
  input wire logic [7:0] flag_mask,
  input wire logic loss_edge_select,
  input wire logic indication_clock_enable,
  input wire logic line_signal_loss_oe,
  input wire logic loss_serial_frame_oe,
  input wire logic loss_serial_frame_o,
  input wire logic [1:0] rx_format,
  input wire logic override_active,
  input wire logic override_data,
  input wire logic override_clock,
  input wire logic loss_clock_select,
  input wire logic rx_data_out,
  input wire logic rx_data_pos,
  input wire logic rx_data_neg,
  input wire logic rx_clock_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // frame pin covers one indication slot of four clocks
  sequence frame_slot;
    loss_serial_frame_o [*4] ##1 !loss_serial_frame_o;
  endsequence
  // loss seen for two samples, so output registers have caught up
  sequence settled_loss;
    loss_status[0] && $past(loss_status[0]) && !override_active &&
      !$past(override_active);
  endsequence
  a_line_flag: assert property (
    $rose(loss_status[0]) |=> irq_flags[0])
    else $error("line loss flag not set");
  a_line_change: assert property (
    $fell(loss_status[0]) && loss_edge_select |=> irq_flags[0])
    else $error("line loss clear flag not set");
  a_sys_flag: assert property (
    $rose(loss_status[1]) |=> irq_flags[1])
    else $error("system loss flag not set");
  a_tx_flag: assert property (
    $rose(loss_status[2]) |=> irq_flags[2])
    else $error("tx loss flag not set");
  a_irq_low: assert property (
    |(irq_flags & ~flag_mask) |-> !irq_n)
    else $error("interrupt not asserted");
  a_serial_float: assert property (
    !indication_clock_enable ##1 !indication_clock_enable |->
      !line_signal_loss_oe && !loss_serial_frame_oe)
    else $error("serial pins driven while clock off");
  a_frame_width: assert property (
    $rose(loss_serial_frame_o) |-> frame_slot)
    else $error("frame pulse width wrong");
  // 22 slots of four clocks each
  a_frame_repeat: assert property (
    $rose(loss_serial_frame_o) |-> ##88 $rose(loss_serial_frame_o))
    else $error("frame period wrong");
  a_rx_forced: assert property (
    settled_loss |-> rx_format == elm_pkg::ELM_RX_SLICED ||
      $past(rx_format) == elm_pkg::ELM_RX_SLICED ||
      (!rx_data_out && !rx_data_pos && !rx_data_neg))
    else $error("receive data not forced low");
  a_rx_clock_high: assert property (
    settled_loss ##0 $past(loss_clock_select) |-> rx_clock_out)
    else $error("receive clock not held high");
  a_override_wins: assert property (
    loss_status[0] && $past(loss_status[0]) && override_active &&
      $past(override_active) |-> rx_data_out == $past(override_data) &&
      rx_clock_out == $past(override_clock))
    else $error("override data not passed");
endmodule
bind elm_monitor elm_monitor_checker u_chk (.*);

// file: verification/elm_line_model.sv
// line and system side source model facing the alarm monitor
`timescale 1ns/1ps
module elm_line_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic line_on,
  input wire logic sys_on,
  input wire logic tx_on,
  input wire logic ais_on,
  output logic rx_tick,
  output logic rx_mark,
  output logic [2:0] rx_amplitude,
  output logic tx_tick,
  output logic tx_mark,
  output logic tx_out_tick,
  output logic [1:0] tx_out_amplitude
);
  logic phase_r;
  logic mark_r;
  // one bit interval every two clocks, marks on alternate bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_r <= 1'b0;
      mark_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
      mark_r <= mark_r ^ phase_r;
    end
  end
  // a dead line carries no level at all, not just a weak one
  assign rx_tick = phase_r;
  assign tx_tick = phase_r;
  assign tx_out_tick = phase_r;
  // all-ones option stands in for an upstream alarm signal
  assign rx_mark = line_on & (mark_r | ais_on);
  assign tx_mark = sys_on & (mark_r | ais_on);
  assign rx_amplitude = line_on ? 3'h7 : 3'h0;
  // released shared line shows no valid pulse
  assign tx_out_amplitude = tx_on ? 2'h3 : 2'h0;
endmodule

// file: verification/tb_e1_loss_of_signal_alarm_monitor.sv
// self-checking bench for the loss-of-signal alarm monitor
`timescale 1ns/1ps
module tb_e1_loss_of_signal_alarm_monitor;
  localparam int unsigned LONG_N = 64;
  logic clk, sys_rst, rx_hdb3, tx_hdb3, rx_tick, rx_mark, rx_data_in;
  logic rx_pos_in, rx_neg_in, rx_clock_in, rx_sliced_pos, rx_sliced_neg;
  logic tx_tick, tx_mark, tx_out_tick, ref_2m_clock, loss_clock_select;
  logic override_active, override_data, override_pos, override_neg;
  logic override_clock, loss_edge_select, tx_loss_edge_select;
  logic ais_edge_select, indication_clock_enable, indication_clock_ctl;
  logic irq_n, rx_data_out, rx_data_pos, rx_data_neg, rx_clock_out;
  logic rx_multiplex_pin, tx_multiplex_pin, indication_clock;
  logic line_signal_loss_o, line_signal_loss_oe, loss_serial_frame_o;
  logic loss_serial_frame_oe, line_on, sys_on, tx_on, ais_on;
  logic [1:0] rx_format, tx_format, tx_out_amplitude;
  logic [2:0] rx_amplitude;
  logic [4:0] error_events;
  logic [7:0] loss_config, flag_clear, flag_mask, loss_status, irq_flags;
  logic [elm_pkg::N_CHAN-1:0] other_line_loss;
  int miscompares, total_checks;

  // long declare count shortened so the run stays brief
  elm_monitor #(.LONG_N(LONG_N)) dut (.*);
  elm_line_model line_model (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // single driver; replaces the unknown start value with 1 on the first edge
  always @(posedge clk) ref_2m_clock <= #1 (ref_2m_clock !== 1'b1);

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic clear_flags();
    flag_clear = 8'hff;
    step(1);
    flag_clear = 8'h00;
    step(1);
  endtask
  task automatic stop_test();
    $display("miscompares=%0d total_checks=%0d", miscompares, total_checks);
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // serial indication: float while off, then one full frame and repeat
  task automatic t_serial();
    other_line_loss = 22'h2a5a53;
    step(4);
    chk({line_signal_loss_oe, loss_serial_frame_oe}, 2'h0);
    indication_clock_enable = 1'b1;
    indication_clock_ctl = 1'b1;
    for (int i = 0; i < 200 && loss_serial_frame_o !== 1'b0; i++) step(1);
    for (int i = 0; i < 200 && loss_serial_frame_o !== 1'b1; i++) step(1);
    chk(indication_clock, 1'b1);
    step(2);
    for (int k = 0; k < 22; k++) begin
      chk(line_signal_loss_o, k == 0 ? 1'b0 : other_line_loss[k]);
      chk(loss_serial_frame_o, k == 0);
      step(4);
    end
    chk(loss_serial_frame_o, 1'b1);
  endtask

  // short criteria: declare at 32, forcing, override, clear, any-change
  task automatic t_line_loss();
    rx_data_in = 1'b1;
    rx_pos_in = 1'b1;
    line_on = 1'b0;
    step(50);
    chk(loss_status[0], 1'b0);
    chk(irq_n, 1'b0);
    flag_mask = 8'h04;
    step(1);
    chk(irq_n, 1'b1);
    flag_mask = 8'h00;
    step(30);
    chk(loss_status[0], 1'b1);
    chk(irq_flags[0], 1'b1);
    chk(irq_n, 1'b0);
    chk({rx_multiplex_pin, error_events[2]}, 2'h3);
    flag_mask = 8'hff;
    step(1);
    chk(irq_n, 1'b1);
    flag_mask = 8'h00;
    for (int f = 0; f < 3; f++) begin
      rx_format = 2'(f);
      step(2);
      chk({rx_data_out, rx_data_pos, rx_data_neg}, 3'h0);
    end
    loss_clock_select = 1'b1;
    step(2);
    chk(rx_clock_out, 1'b1);
    rx_format = elm_pkg::ELM_RX_SLICED;
    rx_sliced_pos = 1'b1;
    step(2);
    chk(rx_data_pos, 1'b1);
    rx_format = elm_pkg::ELM_RX_NRZ1;
    override_active = 1'b1;
    override_data = 1'b1;
    step(2);
    chk({rx_data_out, rx_clock_out}, 2'h2);
    override_active = 1'b0;
    clear_flags();
    chk(irq_flags[0], 1'b0);
    loss_edge_select = 1'b1;
    line_on = 1'b1;
    step(40);
    chk(loss_status[0], 1'b1);
    step(60);
    chk(loss_status[0], 1'b0);
    chk(irq_flags[0], 1'b1);
  endtask

  // long criteria with rising-only flag selection
  task automatic t_long_crit();
    loss_edge_select = 1'b0;
    loss_config[7] = 1'b1;
    clear_flags();
    line_on = 1'b0;
    step(100);
    chk(loss_status[0], 1'b0);
    step(60);
    chk(loss_status[0], 1'b1);
    clear_flags();
    line_on = 1'b1;
    step(100);
    chk(loss_status[0], 1'b0);
    chk(irq_flags[0], 1'b0);
    loss_config[7] = 1'b0;
  endtask

  // system loss only counted in dual-rail formats
  task automatic t_sys_loss();
    tx_hdb3 = 1'b1;
    sys_on = 1'b0;
    step(20);
    chk(irq_n, 1'b1);
    step(80);
    chk({loss_status[1], irq_n}, 2'h0);
    tx_format = elm_pkg::ELM_TX_RZ2;
    step(100);
    chk({loss_status[1], irq_flags[1]}, 2'h3);
    chk({tx_multiplex_pin, error_events[3]}, 2'h3);
    sys_on = 1'b1;
    step(40);
    chk(loss_status[1], 1'b1);
    step(60);
    chk(loss_status[1], 1'b0);
  endtask

  // transmit output loss after 16 intervals, cleared by one pulse
  task automatic t_tx_loss();
    tx_on = 1'b0;
    step(20);
    chk(loss_status[2], 1'b0);
    step(30);
    chk({loss_status[2], irq_flags[2]}, 2'h3);
    tx_loss_edge_select = 1'b1;
    clear_flags();
    tx_on = 1'b1;
    step(8);
    chk({loss_status[2], irq_flags[2]}, 2'h1);
  endtask

  // ais: one dense-free block declares, two dense blocks clear
  task automatic t_ais();
    loss_config[7] = 1'b1;
    ais_on = 1'b1;
    step(2100);
    chk({loss_status[7:6], irq_flags[7:6]}, 4'hf);
    loss_config[7] = 1'b0;
    ais_on = 1'b0;
    step(1000);
    chk(loss_status[7:6], 2'h3);
    step(2200);
    chk(loss_status[7:6], 2'h0);
  endtask

  initial begin
    miscompares = 0;
    total_checks = 0;
    {sys_rst, line_on, sys_on, tx_on} = 4'hf;
    {rx_hdb3, tx_hdb3, rx_data_in, rx_pos_in, rx_neg_in} = 5'h0;
    {rx_clock_in, rx_sliced_pos, rx_sliced_neg} = 3'h0;
    {loss_clock_select, override_active, override_data} = 3'h0;
    {override_pos, override_neg, override_clock, loss_edge_select} = 4'h0;
    {tx_loss_edge_select, ais_edge_select, ais_on} = 3'h0;
    {indication_clock_enable, indication_clock_ctl} = 2'h0;
    rx_format = elm_pkg::ELM_RX_NRZ1;
    tx_format = elm_pkg::ELM_TX_NRZ1;
    loss_config = 8'h24; // threshold 2, tx level 1, period 16
    flag_clear = 8'h00;
    flag_mask = 8'h00;
    other_line_loss = '0;
    repeat (20) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk({loss_status, irq_flags, irq_n}, 17'h00001);
    t_serial();
    t_line_loss();
    t_long_crit();
    t_sys_loss();
    t_tx_loss();
    t_ais();
    stop_test();
  end

  // hang guard, far beyond the roughly six thousand cycles the tests need
  initial begin
    #(4 * 20000);
    miscompares++;
    stop_test();
  end
endmodule
